/* hw/strobe_pkg.sv */
// Constants for the immediate command decoder: opcodes, register offsets,
// field positions and reset values.
// Assumes a 32-bit APB slave with byte addresses, each register one word.
package strobe_pkg;

    // Opcode width and stored-program opcodes
    localparam int OP_W = 8;
    localparam logic [7:0] OP_PROG_MASK_SET = 8'hd4;
    localparam logic [7:0] OP_PROG_MASK_CLR = 8'hd5;

    // Immediate opcodes
    localparam logic [7:0] OP_BEGIN = 8'he1;
    localparam logic [7:0] OP_HALT = 8'he2;
    localparam logic [7:0] OP_RX_ON = 8'he3;
    localparam logic [7:0] OP_MASK_SET = 8'he4;
    localparam logic [7:0] OP_MASK_CLR = 8'he5;
    localparam logic [7:0] OP_ACK = 8'he6;
    localparam logic [7:0] OP_ACK_PEND = 8'he7;
    localparam logic [7:0] OP_NACK = 8'he8;
    localparam logic [7:0] OP_TX_ON = 8'he9;
    localparam logic [7:0] OP_TX_CCA = 8'hea;
    localparam logic [7:0] OP_SAMPLE = 8'heb;
    localparam logic [7:0] OP_FLUSH_RX = 8'hed;
    localparam logic [7:0] OP_FLUSH_TX = 8'hee;
    localparam logic [7:0] OP_RADIO_OFF = 8'hef;
    localparam logic [7:0] OP_ERASE = 8'hff;

    // Register byte offsets
    localparam int ADDR_W = 12;
    localparam logic [11:0] REG_CMD = 12'h000;
    localparam logic [11:0] REG_PROG = 12'h004;
    localparam logic [11:0] REG_MASK = 12'h008;
    localparam logic [11:0] REG_STATUS = 12'h00c;

    // Receive-enable mask layout
    localparam int MASK_W = 8;
    localparam int MASK_BIT = 5;
    localparam logic [7:0] MASK_RESET = 8'h00;

    // Status register bit positions
    localparam int ST_RUNNING = 0;
    localparam int ST_BUSY = 1;
    localparam int ST_CCA = 2;
    localparam int ST_HALTED = 3;
    localparam int ST_PC_LSB = 8;
    localparam int ST_CNT_LSB = 16;

    // Radio strobe vector positions
    localparam int SB_RX_ON = 0;
    localparam int SB_TX_ON = 1;
    localparam int SB_TX_CCA = 2;
    localparam int SB_RADIO_OFF = 3;
    localparam int SB_FLUSH_RX = 4;
    localparam int SB_FLUSH_TX = 5;
    localparam int SB_ACK = 6;
    localparam int SB_ACK_PEND = 7;
    localparam int SB_NACK = 8;
    localparam int SB_N = 9;

    // Default program memory depth
    localparam int PROG_DEPTH_DEF = 24;

endpackage

/* hw/immediate_strobe_decoder.sv */
// Immediate instruction decoder and small stored-program runner of the
// command strobe processor, reached over APB.
// Assumes the radio core returns radio_ack for a strobe that waits on it
// and that channel_clear is synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none

// Operation
// (RULE1) Program opcode d5 clears mask bit 5
// (RULE2) Opcode e2 halts program, sets halt flag
// (RULE3) Opcode e1 zeroes counter, starts program
// (RULE4) Software never starts an already running program
// (RULE5) Opcode e3 strobes receive-on
// (RULE6) Opcode e4 sets mask bit 5
// (RULE7) Opcode e5 clears mask bit 5
// (RULE8) Opcode e9 strobes transmit, waits for acknowledge
// (RULE9) Opcode ea transmits only on clear channel
// (RULE10) Opcode eb samples channel-clear into status
// (RULE11) Opcode ef strobes radio off
// (RULE12) Opcode ed strobes receive flush
// (RULE13) Opcode ee strobes transmit flush
// (RULE14) Opcode e6 strobes acknowledge, pending cleared
// (RULE15) Opcode e7 strobes pending acknowledge, waits
// (RULE16) Opcode e8 suppresses current acknowledge
// (RULE17) Opcode ff erases, resets, aborts without flag
// (RULE18) Software issues erase twice in a row
// (RULE19) Immediates run anytime; unknown opcodes ignored; here a command write stalls while strobe_busy is high
// (RULE20) Strobes one cycle; busy until acknowledge
module immediate_strobe_decoder
#(
    parameter int PROG_DEPTH = strobe_pkg::PROG_DEPTH_DEF
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [strobe_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Radio core side
    input wire logic radio_ack,
    input wire logic channel_clear,
    output logic rx_on_strobe,
    output logic tx_on_strobe,
    output logic tx_if_clear_strobe,
    output logic radio_off_strobe,
    output logic rx_flush_strobe,
    output logic tx_flush_strobe,
    output logic ack_strobe,
    output logic ack_pending_strobe,
    output logic ack_suppress_strobe,
    // Status levels
    output logic [strobe_pkg::MASK_W-1:0] rx_enable_mask,
    output logic program_halted_flag,
    output logic program_running,
    output logic strobe_busy
);
    import strobe_pkg::*;

    localparam int PTR_W = $clog2(PROG_DEPTH + 1);

    ////////////////////////////////////////////////////////////////////////
    // Bus decode

    logic pready_q; // Registered ready, one-cycle pulse
    logic [31:0] prdata_q; // Read data captured with ready
    logic pslverr_q; // Error for unmapped offsets
    logic busy_q; // Waiting for radio acknowledge
    logic access; // Access phase present
    logic stall; // Command write held off while busy
    logic done_wr; // Write takes effect this edge
    logic mapped; // Offset is one of ours
    logic cmd_wr; // Immediate opcode written
    logic [7:0] op; // Opcode being issued

    assign access = psel && penable;
    assign stall = pwrite && (paddr == REG_CMD) && busy_q; // see (RULE8) (RULE15)
    assign done_wr = access && pready_q && pwrite;
    assign mapped = (paddr == REG_CMD) || (paddr == REG_PROG) ||
                    (paddr == REG_MASK) || (paddr == REG_STATUS);
    assign cmd_wr = done_wr && (paddr == REG_CMD); // see (RULE19)
    assign op = pwdata[7:0];

    ////////////////////////////////////////////////////////////////////////
    // Program memory and sequencing

    logic [OP_W-1:0] prog_mem_q [PROG_DEPTH]; // Stored instructions
    logic [PTR_W-1:0] count_q; // Instructions loaded so far
    logic [PTR_W-1:0] pc_q; // Program counter
    logic running_q; // Program executing
    logic erase; // Erase opcode issued
    logic prog_wr; // Append one instruction
    logic [OP_W-1:0] cur_op; // Instruction at the counter

    assign erase = cmd_wr && (op == OP_ERASE);
    assign prog_wr = done_wr && (paddr == REG_PROG) && (count_q < PTR_W'(PROG_DEPTH));
    assign cur_op = (pc_q < PTR_W'(PROG_DEPTH)) ? prog_mem_q[pc_q[PTR_W-1:0]] : '0;

    // One flop group per entry; erase wipes every entry at once
    for (genvar i = 0; i < PROG_DEPTH; i++)
    begin : g_mem
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                prog_mem_q[i] <= '0;
            end
            else if (erase)
            begin
                prog_mem_q[i] <= '0; // see (RULE17)
            end
            else if (prog_wr && (count_q == PTR_W'(i)))
            begin
                prog_mem_q[i] <= pwdata[OP_W-1:0];
            end
        end
    end

    // Load count, cleared with the memory
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count_q <= '0;
        else if (erase)
            count_q <= '0; // see (RULE17)
        else if (prog_wr)
            count_q <= count_q + PTR_W'(1);
    end

    // Counter and run state; one instruction per cycle while running
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pc_q <= '0;
            running_q <= 1'b0;
        end
        else if (erase)
        begin
            // Each erase zeroes the counter, so a repeated erase is harmless
            pc_q <= '0; // see (RULE17) (RULE18)
            running_q <= 1'b0;
        end
        else if (cmd_wr && (op == OP_BEGIN))
        begin
            // Restart from entry zero; an empty memory does not start
            pc_q <= '0; // see (RULE3) (RULE4)
            running_q <= (count_q != '0);
        end
        else if (cmd_wr && (op == OP_HALT))
        begin
            running_q <= 1'b0; // see (RULE2)
        end
        else if (running_q)
        begin
            // Running off the end of the loaded code stops quietly
            if (pc_q + PTR_W'(1) >= count_q)
            begin
                running_q <= 1'b0;
            end
            pc_q <= pc_q + PTR_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive-enable mask

    logic [MASK_W-1:0] mask_q; // Mask register
    logic [MASK_W-1:0] mask_d; // Next mask value

    // Program and immediate edits touch only bit 5; clear beats set
    always_comb
    begin
        mask_d = mask_q;
        if (done_wr && (paddr == REG_MASK))
            mask_d = pwdata[MASK_W-1:0];
        if (running_q && (cur_op == OP_PROG_MASK_SET))
            mask_d[MASK_BIT] = 1'b1;
        if (cmd_wr && (op == OP_MASK_SET))
            mask_d[MASK_BIT] = 1'b1; // see (RULE6)
        if (running_q && (cur_op == OP_PROG_MASK_CLR))
            mask_d[MASK_BIT] = 1'b0; // see (RULE1)
        if (cmd_wr && (op == OP_MASK_CLR))
            mask_d[MASK_BIT] = 1'b0; // see (RULE7)
    end

    // Mask storage
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mask_q <= MASK_RESET;
        else
            mask_q <= mask_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // Radio strobes and handshake

    logic [SB_N-1:0] strobe_q; // One-cycle strobes to the radio
    logic cca_q; // Sampled channel-clear bit
    logic halted_q; // Sticky halt flag

    // Every strobe lives exactly one cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            strobe_q <= '0;
        end
        else
        begin
            strobe_q <= '0; // see (RULE20)
            if (cmd_wr)
            begin
                case (op)
                    OP_RX_ON: strobe_q[SB_RX_ON] <= 1'b1; // see (RULE5)
                    OP_TX_ON: strobe_q[SB_TX_ON] <= 1'b1; // see (RULE8)
                    // Busy channel: no strobe, nothing sent
                    OP_TX_CCA: strobe_q[SB_TX_CCA] <= channel_clear; // see (RULE9)
                    OP_RADIO_OFF: strobe_q[SB_RADIO_OFF] <= 1'b1; // see (RULE11)
                    OP_FLUSH_RX: strobe_q[SB_FLUSH_RX] <= 1'b1; // see (RULE12)
                    OP_FLUSH_TX: strobe_q[SB_FLUSH_TX] <= 1'b1; // see (RULE13)
                    OP_ACK: strobe_q[SB_ACK] <= 1'b1; // see (RULE14)
                    OP_ACK_PEND: strobe_q[SB_ACK_PEND] <= 1'b1; // see (RULE15)
                    OP_NACK: strobe_q[SB_NACK] <= 1'b1; // see (RULE16)
                    default: strobe_q <= '0; // Undefined opcodes do nothing
                endcase
            end
        end
    end

    // Busy from a waiting strobe until the radio acknowledges it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            busy_q <= 1'b0;
        else if (cmd_wr && ((op == OP_TX_ON) || (op == OP_ACK_PEND)))
            busy_q <= 1'b1; // see (RULE8) (RULE15) (RULE20)
        else if (radio_ack)
            busy_q <= 1'b0;
    end

    // Channel-clear sample, kept until the next sample
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cca_q <= 1'b0;
        else if (cmd_wr && (op == OP_SAMPLE))
            cca_q <= channel_clear; // see (RULE10)
    end

    // Halt flag: write one to clear, a halt in the same cycle wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            halted_q <= 1'b0;
        else if (cmd_wr && (op == OP_HALT))
            halted_q <= 1'b1; // see (RULE2)
        else if (done_wr && (paddr == REG_STATUS) && pwdata[ST_HALTED])
            halted_q <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus answer

    // Ready one cycle into the access phase, withheld while stalled
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
            prdata_q <= '0;
            pslverr_q <= 1'b0;
        end
        else if (pready_q || !access || stall)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q <= 1'b1;
            pslverr_q <= !mapped;
            prdata_q <= '0;
            if (!pwrite)
            begin
                case (paddr)
                    REG_MASK: prdata_q <= 32'(mask_q);
                    REG_STATUS:
                    begin
                        prdata_q[ST_RUNNING] <= running_q;
                        prdata_q[ST_BUSY] <= busy_q;
                        prdata_q[ST_CCA] <= cca_q;
                        prdata_q[ST_HALTED] <= halted_q;
                        prdata_q[ST_PC_LSB +: PTR_W] <= pc_q;
                        prdata_q[ST_CNT_LSB +: PTR_W] <= count_q;
                    end
                    default: prdata_q <= '0; // Command and program read zero
                endcase
            end
        end
    end

    // Outputs straight from flops
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign rx_on_strobe = strobe_q[SB_RX_ON];
    assign tx_on_strobe = strobe_q[SB_TX_ON];
    assign tx_if_clear_strobe = strobe_q[SB_TX_CCA];
    assign radio_off_strobe = strobe_q[SB_RADIO_OFF];
    assign rx_flush_strobe = strobe_q[SB_FLUSH_RX];
    assign tx_flush_strobe = strobe_q[SB_FLUSH_TX];
    assign ack_strobe = strobe_q[SB_ACK];
    assign ack_pending_strobe = strobe_q[SB_ACK_PEND];
    assign ack_suppress_strobe = strobe_q[SB_NACK];
    assign rx_enable_mask = mask_q;
    assign program_halted_flag = halted_q;
    assign program_running = running_q;
    assign strobe_busy = busy_q;

endmodule // immediate_strobe_decoder

`default_nettype wire

/* tb/radio_core_model.sv */
// Behavioural radio core facing the strobe outputs of the decoder.
// Assumes strobes are one-cycle pulses and only transmit-on and
// pending acknowledge wait for an answer.
`timescale 1ns/1ps
`default_nettype none
module radio_core_model
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Strobes that wait for an answer
    input wire logic tx_on_strobe,
    input wire logic ack_pending_strobe,
    // Answer delay in cycles, 0 answers two cycles after the strobe
    input wire logic [3:0] ack_delay,
    // Acknowledge back to the decoder
    output logic radio_ack
);
    logic [4:0] cnt_q; // Cycles left before answering, 0 when idle

    // Count down from a waiting strobe, pulse the answer for one cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q <= 5'h00;
            radio_ack <= 1'b0;
        end
        else
        begin
            radio_ack <= (cnt_q == 5'h01);
            if (tx_on_strobe || ack_pending_strobe)
                cnt_q <= {1'b0, ack_delay} + 5'h01;
            else if (cnt_q != 5'h00)
                cnt_q <= cnt_q - 5'h01;
        end
    end
endmodule // radio_core_model
`default_nettype wire

/* tb/strobe_checker_sva.sv */
// Concurrent checks on the ports of the immediate command decoder.
// Assumes one clock domain and no program running during mask commands.
`timescale 1ns/1ps
`default_nettype none
module strobe_checker
    import strobe_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB side
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [strobe_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    // Radio side
    input wire logic radio_ack,
    input wire logic channel_clear,
    input wire logic rx_on_strobe,
    input wire logic tx_on_strobe,
    input wire logic tx_if_clear_strobe,
    input wire logic radio_off_strobe,
    input wire logic ack_pending_strobe,
    // Status levels
    input wire logic [strobe_pkg::MASK_W-1:0] rx_enable_mask,
    input wire logic program_halted_flag,
    input wire logic program_running,
    input wire logic strobe_busy
);
    logic t; // Command write taken this edge
    logic [7:0] op; // Opcode on the write data
    assign t = psel && penable && pready && pwrite && paddr == REG_CMD;
    assign op = pwdata[7:0];
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    //////////////////////////////////////////////////////////////////////
    a_tx_wait: assert property (t && op == OP_TX_ON |=> tx_on_strobe && strobe_busy)
        else $error("transmit strobe or busy missing");
    a_pend_wait: assert property (t && op == OP_ACK_PEND
        |=> ack_pending_strobe && strobe_busy)
        else $error("pending ack strobe or busy missing");
    a_busy_hold: assert property (strobe_busy && !radio_ack |=> strobe_busy)
        else $error("busy dropped before answer");
    a_busy_end: assert property (strobe_busy && radio_ack |=> !strobe_busy)
        else $error("busy stuck after answer");
    a_pulse_one: assert property (tx_on_strobe || rx_on_strobe
        |=> !(tx_on_strobe || rx_on_strobe))
        else $error("strobe longer than one cycle");
    a_mask_set: assert property (t && op == OP_MASK_SET
        |=> rx_enable_mask[MASK_BIT] && rx_enable_mask[4:0] == $past(rx_enable_mask[4:0]))
        else $error("mask set wrong");
    a_mask_clr: assert property (t && op == OP_MASK_CLR
        |=> !rx_enable_mask[MASK_BIT] && rx_enable_mask[7:6] == $past(rx_enable_mask[7:6]))
        else $error("mask clear wrong");
    a_cca_gate: assert property (t && op == OP_TX_CCA
        |=> tx_if_clear_strobe == $past(channel_clear))
        else $error("clear-channel transmit gate wrong");
    a_rf_off: assert property (t && op == OP_RADIO_OFF |=> radio_off_strobe)
        else $error("radio off strobe missing");
    a_rx_on: assert property (t && op == OP_RX_ON |=> rx_on_strobe)
        else $error("receive on strobe missing");
    a_halt_flag: assert property (t && op == OP_HALT
        |=> program_halted_flag && !program_running)
        else $error("halt did not stop and flag");
    a_erase_quiet: assert property (t && op == OP_ERASE && !program_halted_flag
        |=> !program_halted_flag && !program_running)
        else $error("erase raised flag or kept running");
    // Main scenarios reached
    c_gate_shut: cover property (t && op == OP_TX_CCA && !channel_clear);
    c_answer: cover property (strobe_busy && radio_ack);
    c_halted: cover property ($rose(program_halted_flag));
endmodule // strobe_checker
bind immediate_strobe_decoder strobe_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .radio_ack, .channel_clear, .rx_on_strobe, .tx_on_strobe,
    .tx_if_clear_strobe, .radio_off_strobe, .ack_pending_strobe, .rx_enable_mask,
    .program_halted_flag, .program_running, .strobe_busy);
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the immediate command decoder over APB.
// Assumes the radio core model answers waiting strobes after ack_delay.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import strobe_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, channel_clear, radio_ack, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic rx_on_strobe, tx_on_strobe, tx_if_clear_strobe, radio_off_strobe, rx_flush_strobe;
    logic tx_flush_strobe, ack_strobe, ack_pending_strobe, ack_suppress_strobe;
    logic [7:0] rx_enable_mask, op, m;
    logic program_halted_flag, program_running, strobe_busy, er, bz;
    logic [3:0] ack_delay;
    logic [SB_N-1:0] sb, xs; // Strobes seen and expected after a command
    logic [7:0] ops [11]; // Command table
    int errors = 0, n_checks = 0, seed = 80615, i;
    immediate_strobe_decoder uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .radio_ack, .channel_clear, .rx_on_strobe, .tx_on_strobe,
        .tx_if_clear_strobe, .radio_off_strobe, .rx_flush_strobe, .tx_flush_strobe, .ack_strobe,
        .ack_pending_strobe, .ack_suppress_strobe, .rx_enable_mask, .program_halted_flag,
        .program_running, .strobe_busy);
    radio_core_model far (.pclk, .presetn, .tx_on_strobe, .ack_pending_strobe, .ack_delay,
        .radio_ack);
    //////////////////////////////////////////////////////////////////////
    // Free-running 200 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // Compare and count
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Expected strobe vector; clear-channel transmit only on a clear channel
    function automatic logic [SB_N-1:0] exp_sb(input logic [7:0] o, input logic cc);
        exp_sb = '0;
        case (o)
            OP_RX_ON: exp_sb[SB_RX_ON] = 1'b1;
            OP_TX_ON: exp_sb[SB_TX_ON] = 1'b1;
            OP_TX_CCA: exp_sb[SB_TX_CCA] = cc;
            OP_RADIO_OFF: exp_sb[SB_RADIO_OFF] = 1'b1;
            OP_FLUSH_RX: exp_sb[SB_FLUSH_RX] = 1'b1;
            OP_FLUSH_TX: exp_sb[SB_FLUSH_TX] = 1'b1;
            OP_ACK: exp_sb[SB_ACK] = 1'b1;
            OP_ACK_PEND: exp_sb[SB_ACK_PEND] = 1'b1;
            OP_NACK: exp_sb[SB_NACK] = 1'b1;
            default: exp_sb = '0; // Undefined codes do nothing
        endcase
    endfunction
    // One APB transfer; holds the request until pready is sampled high
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        while (pready !== 1'b1) @(posedge pclk); // Only the watchdog ends a hung wait
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
        sb = {ack_suppress_strobe, ack_pending_strobe, ack_strobe, tx_flush_strobe,
            rx_flush_strobe, radio_off_strobe, tx_if_clear_strobe, tx_on_strobe, rx_on_strobe};
        bz = strobe_busy;
    endtask
    // Verdict, the single end of the run
    task finish_test;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Watchdog against a hung handshake
    initial
    begin
        #100000;
        errors++;
        finish_test;
    end
    //////////////////////////////////////////////////////////////////////
    initial
    begin
        {presetn, psel, penable, pwrite, channel_clear} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        ack_delay = 4'h0;
        ops = '{OP_RX_ON, OP_TX_ON, OP_TX_CCA, OP_TX_CCA, OP_RADIO_OFF, OP_FLUSH_RX,
            OP_FLUSH_TX, OP_ACK, OP_ACK_PEND, OP_NACK, 8'hec};
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        chk("mask after reset", rx_enable_mask, MASK_RESET);
        // Every strobe command, then random undefined codes
        for (i = 0; i < 19; i++)
        begin
            op = (i < 11) ? ops[i] : {2'b00, 6'($random(seed))};
            @(posedge pclk);
            channel_clear <= i[0];
            ack_delay <= 4'($random(seed));
            bus(1'b1, REG_CMD, {24'h0, op});
            xs = exp_sb(op, i[0]);
            chk("radio strobes", sb[3:0], xs[3:0]);
            chk("flush strobes", sb[5:4], xs[5:4]);
            chk("ack strobes", sb[8:6], xs[8:6]);
            chk("busy", bz, op == OP_TX_ON || op == OP_ACK_PEND);
        end
        $display("strobe test done");
        // Mask set and clear keep the other bits
        m = 8'($random(seed));
        bus(1'b1, REG_MASK, {24'h0, m});
        bus(1'b1, REG_CMD, {24'h0, OP_MASK_SET});
        bus(1'b0, REG_MASK, 32'h0);
        chk("mask set", rd, {24'h0, m | 8'h20});
        bus(1'b1, REG_CMD, {24'h0, OP_MASK_CLR});
        bus(1'b0, REG_MASK, 32'h0);
        chk("mask clear", rd, {24'h0, m & 8'hdf});
        // Stored program clearing the mask bit
        bus(1'b1, REG_MASK, {24'h0, m | 8'h20});
        bus(1'b1, REG_PROG, {24'h0, OP_PROG_MASK_CLR});
        bus(1'b1, REG_CMD, {24'h0, OP_BEGIN});
        repeat (6) @(posedge pclk);
        bus(1'b0, REG_MASK, 32'h0);
        chk("program mask", rd, {24'h0, m & 8'hdf});
        bus(1'b0, REG_STATUS, 32'h0);
        chk("program end", {rd[ST_HALTED], rd[ST_RUNNING]}, 2'b00);
        $display("mask test done");
        // Halt a long program in mid-run
        for (i = 0; i < 10; i++) bus(1'b1, REG_PROG, 32'h0);
        bus(1'b1, REG_CMD, {24'h0, OP_BEGIN});
        @(posedge pclk);
        #1 chk("running", program_running, 1'b1);
        bus(1'b1, REG_CMD, {24'h0, OP_HALT});
        chk("halt", {program_halted_flag, program_running}, 2'b10);
        // Erase twice, clear flag first
        bus(1'b1, REG_STATUS, 32'h8);
        bus(1'b1, REG_CMD, {24'h0, OP_ERASE});
        bus(1'b1, REG_CMD, {24'h0, OP_ERASE});
        bus(1'b0, REG_STATUS, 32'h0);
        chk("erase", {rd[20:16], rd[12:8], rd[ST_HALTED], rd[ST_RUNNING]}, 32'h0);
        bus(1'b1, REG_CMD, {24'h0, OP_BEGIN});
        @(posedge pclk);
        #1 chk("empty start", program_running, 1'b0);
        $display("program test done");
        // Channel sample, clear first so a stuck reset value shows up
        for (i = 0; i < 2; i++)
        begin
            @(posedge pclk);
            channel_clear <= !i[0];
            bus(1'b1, REG_CMD, {24'h0, OP_SAMPLE});
            bus(1'b0, REG_STATUS, 32'h0);
            chk("sampled clear", rd[ST_CCA], !i[0]);
        end
        bus(1'b0, 12'h010, 32'h0);
        chk("unmapped error", er, 1'b1);
        $display("sample test done");
        finish_test;
    end
endmodule // tb_top
`default_nettype wire
